// ### verilog/power_mode_pkg.sv
// Constants, register layout and mode type of the power mode controller
package power_mode_pkg;

  // Clock rates and the derived 32 kHz tick divider
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TICK_HZ     = 32_768;
  localparam int unsigned TICK_DIV    = CLK_HZ / TICK_HZ;
  localparam logic [11:0] TICK_DIV_M1 = 12'(TICK_DIV - 1);

  // Power control register
  localparam logic [7:0]  PWR_CTRL_ADDR  = 8'h1B;
  localparam int unsigned INV_BIT        = 6;
  localparam int unsigned DLY_MSB        = 5;
  localparam int unsigned DLY_LSB        = 4;
  localparam logic [7:0]  PWR_CTRL_RESET = 8'h10;
  localparam logic [7:0]  PWR_CTRL_MASK  = 8'h70;

  // Standby pin synchroniser depth in 32 kHz ticks
  localparam int unsigned SYNC_STAGES = 3;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_COIN,
    MODE_OFF,
    MODE_ON,
    MODE_SLEEP,
    MODE_STANDBY
  } mode_t;

endpackage : power_mode_pkg

// ### verilog/tick_divider.sv
// Divider giving a one-cycle 32 kHz tick from the system clock
`timescale 1ns/1ps
module tick_divider
  import power_mode_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  output logic      tick_o
);

  logic [11:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Free running count, wraps at the divide value
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q  <= 12'h000;
      tick_o <= 1'b0;
    end else if (cnt_q == TICK_DIV_M1) begin
      cnt_q  <= 12'h000;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 12'h001;
      tick_o <= 1'b0;
    end
  end

endmodule : tick_divider

// ### verilog/standby_sync.sv
// Tick-paced shift synchroniser for the standby control level
`timescale 1ns/1ps
module standby_sync #(
  parameter int unsigned STAGES = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic tick_i,
  input  wire logic clr_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic [STAGES-1:0] sh_q;

  ////////////////////////////////////////////////////////////////////////
  // Shift on each tick; clear forces the inactive level
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh_q <= '0;
    end else if (clr_i) begin
      sh_q <= '0;
    end else if (tick_i) begin
      sh_q <= {sh_q[STAGES-2:0], d_i};
    end
  end

  // Only the last stage is visible outside
  assign q_o = sh_q[STAGES-1];

endmodule : standby_sync

// ### verilog/power_mode_state_control.sv
// Operating mode controller: mode machine, standby path and control register
`timescale 1ns/1ps
// Function
// R1 - Exactly one of ON, OFF, Sleep, Standby, Coin Cell is held.
// R2 - No power-up unless supply is above the undervoltage threshold.
// R3 - Register accesses are ignored in Coin Cell.
// R4 - Interrupt output may assert only in Sleep, Standby or ON.
// R5 - Turn-on event moves to ON; processor reset released in ON.
// R6 - Turn-off or thermal shutdown forces OFF from powered states.
// R7 - Processor reset held low in OFF.
// R8 - OFF is left toward ON only on a valid turn-on event.
// R9 - Active standby control enters Standby; inactive returns to ON.
// R10 - Standby control is pin level XOR polarity-invert bit.
// R11 - Standby pin acts only from ON.
// R12 - First power-up copies ON settings into Standby settings.
// R13 - Polarity-invert is bit 6 of register 0x1B, read and write.
// R14 - Host sets polarity first, then adjusts Standby regulator settings.
// R15 - Nonzero holdoff field delays the Standby response until expiry.
// R16 - Holdoff codes 0 to 3 give that many 32 kHz periods; reset 01.
// R17 - Standby pin passes a three-tick synchroniser before the holdoff.
// R18 - Holdoff field sits in bits 5:4 of register 0x1B.
// R19 - Coin Cell rejects turn-on; moves to OFF when supply recovers.
// R20 - Synchroniser and holdoff run on the 32 kHz tick, clear off ON; the code keeps the synchroniser running in Standby.
module power_mode_state_control
  import power_mode_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       supply_above_uv_i,
  input  wire logic       turn_on_event_i,
  input  wire logic       turn_off_event_i,
  input  wire logic       sleep_event_i,
  input  wire logic       thermal_shutdown_i,
  input  wire logic       standby_pin_i,
  input  wire logic       irq_pending_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_ack_o,
  output logic            processor_reset_out_n_o,
  output logic            interrupt_out_n_o,
  output logic            mirror_standby_o,
  output mode_t           mode_o
);

  mode_t      mode_q;
  mode_t      mode_d;
  logic [7:0] pwr_ctrl_q;
  logic       tick;
  logic       ctl_raw;
  logic       ctl_sync;
  logic       sync_clr;
  logic       armed_q;
  logic [1:0] holdoff_q;
  logic       go_standby;
  logic       booted_q;
  logic       bus_open;
  logic       powered;

  ////////////////////////////////////////////////////////////////////////
  // 32 kHz tick and standby synchroniser

  // R20 - shared tick
  tick_divider u_tick (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (tick)
  );

  // R10 - polarity applied
  // Polarity is folded in before sync so a flip is also qualified
  assign ctl_raw = standby_pin_i ^ pwr_ctrl_q[INV_BIT];

  // R11 - pin ignored elsewhere
  // Standby keeps the sync alive so exit can still be seen
  assign sync_clr = (mode_q != MODE_ON) && (mode_q != MODE_STANDBY);

  // R17 - three tick sync
  standby_sync #(
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (tick),
    .clr_i   (sync_clr),
    .d_i     (ctl_raw),
    .q_o     (ctl_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Standby holdoff counter

  // R15 - holdoff countdown
  // R20 - cleared off ON
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      armed_q   <= 1'b0;
      holdoff_q <= 2'h0;
    end else if (mode_q != MODE_ON || !ctl_sync) begin
      armed_q   <= 1'b0;
      holdoff_q <= 2'h0;
    end else if (!armed_q) begin
      armed_q   <= 1'b1;
      holdoff_q <= pwr_ctrl_q[DLY_MSB:DLY_LSB];
    end else if (tick && holdoff_q != 2'h0) begin
      holdoff_q <= holdoff_q - 2'h1;
    end
  end

  // R16 - zero code means no wait
  assign go_standby = ctl_sync && armed_q && (holdoff_q == 2'h0);

  ////////////////////////////////////////////////////////////////////////
  // Mode machine

  // R1 - single mode register
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      // R19 - coin rejects turn-on
      MODE_COIN: begin
        if (supply_above_uv_i) mode_d = MODE_OFF;
      end
      // R8 - only turn-on exits toward ON; supply loss exits to COIN
      // R2 - supply qualifies power-up
      MODE_OFF: begin
        if (!supply_above_uv_i) mode_d = MODE_COIN;
        else if (turn_on_event_i) mode_d = MODE_ON;
      end
      // R6 - thermal and turn-off
      MODE_SLEEP: begin
        if (!supply_above_uv_i) mode_d = MODE_COIN;
        else if (thermal_shutdown_i) mode_d = MODE_OFF;
        else if (turn_off_event_i) mode_d = MODE_OFF;
        else if (turn_on_event_i) mode_d = MODE_ON;
      end
      // R9 - standby exit
      MODE_STANDBY: begin
        if (!supply_above_uv_i) mode_d = MODE_COIN;
        else if (thermal_shutdown_i) mode_d = MODE_OFF;
        else if (turn_off_event_i) mode_d = MODE_OFF;
        else if (sleep_event_i) mode_d = MODE_SLEEP;
        else if (!ctl_sync) mode_d = MODE_ON;
      end
      // R9 - standby entry
      MODE_ON: begin
        if (!supply_above_uv_i) mode_d = MODE_COIN;
        else if (thermal_shutdown_i) mode_d = MODE_OFF;
        else if (turn_off_event_i) mode_d = MODE_OFF;
        else if (sleep_event_i) mode_d = MODE_SLEEP;
        else if (go_standby) mode_d = MODE_STANDBY;
      end
      default: begin
        mode_d = MODE_COIN;
      end
    endcase
  end

  // Reset starts without supply assumed
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= MODE_COIN;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign mode_o = mode_q;

  ////////////////////////////////////////////////////////////////////////
  // Processor reset, interrupt gate and first power-up mirror

  // R5 - released in ON
  // R7 - low in OFF
  // Registered from the next mode so it tracks mode_q exactly
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      processor_reset_out_n_o <= 1'b0;
    end else begin
      processor_reset_out_n_o <= (mode_d == MODE_ON) ||
                                 (mode_d == MODE_STANDBY);
    end
  end

  // R4 - interrupt gated by mode
  assign powered = (mode_q == MODE_ON) || (mode_q == MODE_SLEEP) ||
                   (mode_q == MODE_STANDBY);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_out_n_o <= 1'b1;
    end else begin
      // Next mode, so the gate is already shut on the edge that enters OFF
      interrupt_out_n_o <= !(irq_pending_i &&
                             ((mode_d == MODE_ON) ||
                              (mode_d == MODE_SLEEP) ||
                              (mode_d == MODE_STANDBY)));
    end
  end

  // R12 - one-shot settings mirror
  // Only the first ON entry after reset; later entries keep host edits
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      booted_q         <= 1'b0;
      mirror_standby_o <= 1'b0;
    end else begin
      mirror_standby_o <= 1'b0;
      if (!booted_q && mode_d == MODE_ON && mode_q != MODE_ON) begin
        booted_q         <= 1'b1;
        mirror_standby_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power control register port

  // R3 - no access in coin cell
  assign bus_open = (mode_q != MODE_COIN);

  // R13 - polarity bit storage
  // R18 - holdoff field storage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_ctrl_q <= PWR_CTRL_RESET;
    end else if (reg_wr_i && bus_open &&
                 reg_addr_i == PWR_CTRL_ADDR) begin
      pwr_ctrl_q <= reg_wdata_i & PWR_CTRL_MASK;
    end
  end

  // R3 - silent in coin cell
  // Unmapped reads answer zero; unused bits read zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_ack_o   <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      reg_ack_o <= (reg_wr_i || reg_rd_i) && bus_open;
      if (reg_rd_i && bus_open && reg_addr_i == PWR_CTRL_ADDR) begin
        reg_rdata_o <= pwr_ctrl_q;
      end else if (reg_rd_i && bus_open) begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_one_mode;
    mode_q inside {MODE_COIN, MODE_OFF, MODE_ON, MODE_SLEEP, MODE_STANDBY};
  endproperty
  a_one_mode: assert property (p_one_mode) // R1
    else $error("mode register left the five modes");

  property p_no_powerup;
    (mode_q == MODE_OFF && !supply_above_uv_i) |=> mode_q != MODE_ON;
  endproperty
  a_no_powerup: assert property (p_no_powerup) // R2
    else $error("power-up without supply");

  property p_coin_silent;
    (mode_q == MODE_COIN && (reg_wr_i || reg_rd_i)) |=>
      !reg_ack_o && $stable(pwr_ctrl_q);
  endproperty
  a_coin_silent: assert property (p_coin_silent) // R3
    else $error("register access taken in coin cell");

  property p_int_gate;
    (mode_q == MODE_OFF || mode_q == MODE_COIN) |-> interrupt_out_n_o;
  endproperty
  a_int_gate: assert property (p_int_gate) // R4
    else $error("interrupt asserted while unpowered");

  property p_reset_level;
    (mode_q == MODE_ON |-> processor_reset_out_n_o) and
    (mode_q == MODE_OFF |-> !processor_reset_out_n_o);
  endproperty
  a_reset_level: assert property (p_reset_level) // R5 R7
    else $error("processor reset level wrong for mode");

  property p_thermal_off;
    (thermal_shutdown_i && supply_above_uv_i && powered) |=>
      mode_q == MODE_OFF;
  endproperty
  a_thermal_off: assert property (p_thermal_off) // R6
    else $error("thermal shutdown did not force OFF");

  property p_off_exit;
    (mode_q == MODE_OFF && !turn_on_event_i) |=>
      mode_q inside {MODE_OFF, MODE_COIN};
  endproperty
  a_off_exit: assert property (p_off_exit) // R8
    else $error("left OFF without turn-on");

  property p_holdoff;
    (mode_q == MODE_ON && holdoff_q != 2'h0) |=> mode_q != MODE_STANDBY;
  endproperty
  a_holdoff: assert property (p_holdoff) // R15
    else $error("standby entered before holdoff expired");

  property p_coin_hold;
    (mode_q == MODE_COIN && !supply_above_uv_i) |=> mode_q == MODE_COIN;
  endproperty
  a_coin_hold: assert property (p_coin_hold) // R19
    else $error("coin cell left without supply");

  property p_sync_clear;
    (mode_q == MODE_OFF) |=> !ctl_sync && !armed_q;
  endproperty
  a_sync_clear: assert property (p_sync_clear) // R20
    else $error("standby path not cleared off ON");

  c_enter_standby: cover property (
    mode_q == MODE_ON ##1 mode_q == MODE_STANDBY);
  c_exit_standby: cover property (
    mode_q == MODE_STANDBY ##1 mode_q == MODE_ON);
  c_coin_to_off: cover property (
    mode_q == MODE_COIN ##1 mode_q == MODE_OFF);
  c_sleep: cover property (mode_q == MODE_SLEEP);

endmodule : power_mode_state_control

// ### bench/host_processor_model.sv
// Processor model that drives the standby pin toward the controller
`timescale 1ns/1ps
module host_processor_model (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic want_standby_i,
  input  wire logic active_low_i,
  output logic      standby_pin_o
);
  logic float_q = 1'b0;

  // A pin held in reset floats; toggle it so a stale level never helps
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  // polarity first
  // The bench writes the invert bit before active_low_i follows it
  assign standby_pin_o = reset_n_i ? (want_standby_i ^ active_low_i)
                                   : float_q;
endmodule : host_processor_model

// ### bench/power_mode_state_control_bench.sv
// Self-checking bench for the operating mode controller
`timescale 1ns/1ps
module power_mode_state_control_bench
  import power_mode_pkg::*;
;
  localparam int D = int'(TICK_DIV);
  logic        clk = 1'b0;
  logic        rst_b, supply, on_ev, off_ev, sleep_ev, hot, irq;
  logic        wr, rd, want, active_low, pin, ack, rst_n, int_n, mirror;
  logic [7:0]  addr, wdata, rdata;
  mode_t       mode;
  logic [8:0]  notes[$];
  logic [8:0]  note;
  logic [31:0] seed;
  int          failures, comparisons;

  power_mode_state_control dut_u (
    .clk_i(clk), .rst_b_i(rst_b), .supply_above_uv_i(supply),
    .turn_on_event_i(on_ev), .turn_off_event_i(off_ev),
    .sleep_event_i(sleep_ev), .thermal_shutdown_i(hot),
    .standby_pin_i(pin), .irq_pending_i(irq), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .processor_reset_out_n_o(rst_n),
    .interrupt_out_n_o(int_n), .mirror_standby_o(mirror), .mode_o(mode));

  host_processor_model host_u (
    .clk_i(clk), .reset_n_i(rst_n), .want_standby_i(want),
    .active_low_i(active_low), .standby_pin_o(pin));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cm(input mode_t m);
    chk("mode_o", {5'h00, m}, {5'h00, mode});
  endtask : cm

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  // Bounded wait; counts negedges from the launching edge
  task automatic wait_mode(input mode_t m, input int lim, output int n);
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_mode

  // One register access; an expected answer is noted for the watcher
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic acked, input logic [7:0] e);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (acked) notes.push_back({!w, e});
  endtask : acc

  task automatic idle();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : idle

  task automatic complete_run();
    chk("pending_acks", 8'h00, 8'(notes.size()));
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////
  // Ack watcher: an ack with nothing noted means a refused access got in
  always @(negedge clk) begin
    if (rst_b && ack !== 1'b0) begin
      if (notes.size() == 0) begin
        chk("reg_ack_o", 8'h00, {7'h00, ack});
      end else begin
        note = notes.pop_front();
        if (note[8]) chk("reg_rdata_o", note[7:0], rdata);
      end
    end
  end

  // Watchdog; the scenarios need about 65k cycles
  initial begin
    repeat (95000) @(posedge clk);
    failures++;
    complete_run();
  end

  // Main sequence
  initial begin
    int n;
    rst_b = 1'b0;
    {supply, on_ev, off_ev, sleep_ev, hot, irq, wr, rd} = '0;
    {want, active_low, addr, wdata} = '0;
    seed = 32'h1030;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    irq <= 1'b1;
    on_ev <= 1'b1;
    wait_n(3);
    cm(MODE_COIN);
    chk("interrupt_out_n_o", 8'h01, {7'h00, int_n});
    acc(1'b0, 8'h1B, 8'h00, 1'b0, 8'h00);
    acc(1'b1, 8'h1B, 8'hFF, 1'b0, 8'h00);
    idle();
    @(posedge clk);
    on_ev <= 1'b0;
    supply <= 1'b1;
    wait_n(2);
    cm(MODE_OFF);
    chk("processor_reset_out_n_o", 8'h00, {7'h00, rst_n});
    chk("interrupt_out_n_o", 8'h01, {7'h00, int_n});
    // Back-to-back accesses, unmapped address and reserved bits
    acc(1'b0, 8'h1B, 8'h00, 1'b1, 8'h10);
    acc(1'b0, 8'h6A, 8'h00, 1'b1, 8'h00);
    acc(1'b1, 8'h1B, 8'hFF, 1'b1, 8'h00);
    acc(1'b0, 8'h1B, 8'h00, 1'b1, 8'h70);
    acc(1'b1, 8'h6A, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 8'h1B, 8'h00, 1'b1, 8'h70);
    idle();
    // Supply loss, rejected turn-on, then the first power-up
    @(posedge clk);
    supply <= 1'b0;
    wait_n(2);
    cm(MODE_COIN);
    @(posedge clk);
    on_ev <= 1'b1;
    wait_n(4);
    cm(MODE_COIN);
    @(posedge clk);
    supply <= 1'b1;
    wait_n(2);
    cm(MODE_OFF);
    wait_n(1);
    cm(MODE_ON);
    chk("processor_reset_out_n_o", 8'h01, {7'h00, rst_n});
    chk("mirror_standby_o", 8'h01, {7'h00, mirror});
    @(posedge clk);
    on_ev <= 1'b0;
    wait_n(1);
    chk("interrupt_out_n_o", 8'h00, {7'h00, int_n});
    // Every holdoff code, both polarities
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      sleep_ev <= 1'b1;
      @(posedge clk);
      sleep_ev <= 1'b0;
      wait_n(1);
      cm(MODE_SLEEP);
      chk("interrupt_out_n_o", 8'h00, {7'h00, int_n});
      acc(1'b1, 8'h1B, {1'b0, c[0], c[1:0], 4'h0}, 1'b1, 8'h00);
      acc(1'b0, 8'h1B, 8'h00, 1'b1, {1'b0, c[0], c[1:0], 4'h0});
      idle();
      active_low <= c[0];
      on_ev <= 1'b1;
      @(posedge clk);
      on_ev <= 1'b0;
      wait_n(1);
      cm(MODE_ON);
      chk("mirror_standby_o", 8'h00, {7'h00, mirror});
      wait_n(4 * D);
      cm(MODE_ON);
      @(posedge clk);
      want <= 1'b1;
      wait_mode(MODE_STANDBY, (4 + c) * D, n);
      chk("standby_entry_ok", 8'h01,
          {7'h00, n >= (2 + c) * D && n <= (3 + c) * D + 8});
      chk("interrupt_out_n_o", 8'h00, {7'h00, int_n});
      @(posedge clk);
      want <= 1'b0;
      wait_mode(MODE_ON, 4 * D, n);
      cm(MODE_ON);
    end
    // Thermal shutdown out of Standby
    @(posedge clk);
    want <= 1'b1;
    wait_mode(MODE_STANDBY, 8 * D, n);
    cm(MODE_STANDBY);
    @(posedge clk);
    hot <= 1'b1;
    want <= 1'b0;
    @(posedge clk);
    hot <= 1'b0;
    wait_n(1);
    cm(MODE_OFF);
    chk("processor_reset_out_n_o", 8'h00, {7'h00, rst_n});
    // Random noise in OFF without a turn-on event
    for (int i = 0; i < 64; i++) begin
      seed = xs(seed);
      @(posedge clk);
      sleep_ev <= seed[0];
      off_ev <= seed[1];
      hot <= seed[2];
      irq <= seed[3];
      want <= seed[4];
      @(negedge clk);
      cm(MODE_OFF);
      chk("interrupt_out_n_o", 8'h01, {7'h00, int_n});
    end
    @(posedge clk);
    {sleep_ev, off_ev, hot, want} <= '0;
    on_ev <= 1'b1;
    @(posedge clk);
    on_ev <= 1'b0;
    wait_n(1);
    cm(MODE_ON);
    chk("mirror_standby_o", 8'h00, {7'h00, mirror});
    // Turn-off taken from Sleep as well
    @(posedge clk);
    sleep_ev <= 1'b1;
    @(posedge clk);
    sleep_ev <= 1'b0;
    wait_n(1);
    cm(MODE_SLEEP);
    @(posedge clk);
    off_ev <= 1'b1;
    @(posedge clk);
    off_ev <= 1'b0;
    wait_n(1);
    cm(MODE_OFF);
    @(posedge clk);
    supply <= 1'b0;
    wait_n(2);
    cm(MODE_COIN);
    acc(1'b0, 8'h1B, 8'h00, 1'b0, 8'h00);
    idle();
    wait_n(3);
    complete_run();
  end
endmodule : power_mode_state_control_bench
